// file: rtl/dreg_backup_pkg.sv
// constants, register map and encodings shared by the data register
// retention and backup block
// assumes one 20 MHz system clock and a 32-bit APB register bus
package dreg_backup_pkg;

  localparam int          DATA_W       = 16;
  localparam int          IDX_W        = 11;
  localparam int          NV_ADDR_W    = 12;
  localparam int          DREG_DEPTH   = 2000;

  // highest ordinary data register index and backup span per variant
  localparam logic [IDX_W-1:0]  LAST_LARGE   = 11'h7CF;
  localparam logic [IDX_W-1:0]  LAST_SMALL   = 11'h18F;
  localparam logic [16:0]       SPAN_LARGE   = 17'h007D0;
  localparam logic [16:0]       SPAN_SMALL   = 17'h00190;

  // result codes of the status register
  localparam logic [DATA_W-1:0] ST_NONE      = 16'h0000;
  localparam logic [DATA_W-1:0] ST_BUSY      = 16'h0001;
  localparam logic [DATA_W-1:0] ST_OK        = 16'h0002;
  localparam logic [DATA_W-1:0] ST_NOACCESS  = 16'h0003;
  localparam logic [DATA_W-1:0] ST_BADPARAM  = 16'h0004;
  localparam logic [DATA_W-1:0] ST_NODATA    = 16'h0005;

  // validity marker word stored after the data image; value is arbitrary
  localparam logic [NV_ADDR_W-1:0] MARKER_ADDR  = 12'h7D0;
  localparam logic [DATA_W-1:0]    MARKER_VALID = 16'hA5C3;
  localparam logic [DATA_W-1:0]    MARKER_VOID  = 16'h0000;

  // APB byte offsets
  localparam logic [11:0] OFS_MODE          = 12'h000;
  localparam logic [11:0] OFS_REQUEST       = 12'h004;
  localparam logic [11:0] OFS_CLEAR_FIRST   = 12'h008;
  localparam logic [11:0] OFS_CLEAR_LAST    = 12'h00C;
  localparam logic [11:0] OFS_STATUS        = 12'h010;
  localparam logic [11:0] OFS_RESTORE_START = 12'h014;
  localparam logic [11:0] OFS_RESTORE_COUNT = 12'h018;
  localparam logic [11:0] OFS_DREG_INDEX    = 12'h01C;
  localparam logic [11:0] OFS_DREG_DATA     = 12'h020;
  localparam logic [11:0] OFS_INFO          = 12'h024;

  // request register bit positions
  localparam int          REQ_WRITE_BIT     = 0;
  localparam int          REQ_READ_BIT      = 1;

  typedef enum logic [1:0] {
    KEEP_ALL,
    CLEAR_ALL,
    CLEAR_RANGE
  } keep_mode_e;

  localparam keep_mode_e  MODE_RESET        = KEEP_ALL;
  localparam logic [IDX_W-1:0] CLEAR_FIRST_RESET = 11'h000;
  localparam logic [IDX_W-1:0] CLEAR_LAST_RESET  = 11'h000;

endpackage

// file: rtl/pin_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the pins are static for several cycles around each change
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= pin_i;
      sync_o <= stage1;
    end
  end

endmodule
`default_nettype wire

// file: rtl/dreg_array.sv
// data register array with start-of-operation keep/clear handling
// assumes clear_i is a one-cycle pulse at the start of operation
`timescale 1ns/10ps
`default_nettype none
module dreg_array
  import dreg_backup_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              clear_i,
  input  wire keep_mode_e        mode_i,
  input  wire logic [IDX_W-1:0]  first_i,
  input  wire logic [IDX_W-1:0]  last_i,
  input  wire logic              we_i,
  input  wire logic [IDX_W-1:0]  widx_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [IDX_W-1:0]  ridx_a_i,
  output logic      [DATA_W-1:0] rdata_a_o,
  input  wire logic [IDX_W-1:0]  ridx_b_i,
  output logic      [DATA_W-1:0] rdata_b_o
);

  // no reset: contents must survive power-off until operation begins
  logic [DATA_W-1:0] mem [DREG_DEPTH];

  for (genvar i = 0; i < DREG_DEPTH; i++) begin : g_word
    localparam logic [IDX_W-1:0] IDX = IDX_W'(i);
    logic in_range;
    assign in_range = (IDX >= first_i) && (IDX <= last_i);
    always_ff @(posedge clk_i) begin
      if (clear_i && (mode_i == CLEAR_ALL)) begin
        mem[i] <= '0;
      end else if (clear_i && (mode_i == CLEAR_RANGE) && in_range) begin
        mem[i] <= '0;
      end else if (we_i && (widx_i == IDX)) begin
        mem[i] <= wdata_i;
      end
    end
  end

  assign rdata_a_o = (ridx_a_i <= LAST_LARGE) ? mem[ridx_a_i] : '0;
  assign rdata_b_o = (ridx_b_i <= LAST_LARGE) ? mem[ridx_b_i] : '0;

endmodule
`default_nettype wire

// file: rtl/dreg_backup.sv
// data register retention, nonvolatile backup and restore, APB slave
// assumes scan_end_i and run_start_i are one-cycle pulses on clk_i and
// that the nonvolatile store answers each request with one nv_ack_i pulse
//
// Contract
// - keep-all mode preserves every data register
// - clear-all mode zeroes every register at start
// - clear-range zeroes first through last inclusive
// - range indices accepted only within 0 to 1999
// - clearing happens only when operation starts
// - special registers always clear at start
// - write request copies span, posts status, clears
// - read request restores start/count, posts status, clears
// - span 0-399 small, 0-1999 large variant
// - cartridge present redirects all transfers there
// - status codes one through five report result
// - code 3 for seating, failure, missing store
// - code 4 for bad restore parameters
// - code 5 for missing or interrupted image
// - both requests: write, then read, one status
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dreg_backup
  import dreg_backup_pkg::*;
#(
  parameter bit SMALL_VARIANT  = 1'b0,
  parameter bit INTERNAL_STORE = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 scan_end_i,
  input  wire logic                 run_start_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic                 cart_present_i,
  input  wire logic                 cart_fault_i,
  output logic                      nv_req_o,
  output logic                      nv_we_o,
  output logic                      nv_cart_o,
  output logic      [NV_ADDR_W-1:0] nv_addr_o,
  output logic      [DATA_W-1:0]    nv_wdata_o,
  input  wire logic [DATA_W-1:0]    nv_rdata_i,
  input  wire logic                 nv_ack_i,
  input  wire logic                 nv_err_i
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_WR_OPEN,
    S_WR_WORD,
    S_WR_SEAL,
    S_RD_CHECK,
    S_RD_MARK,
    S_RD_WORD,
    S_FINISH
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_meta;
  logic       rst_n;
  logic [1:0] cart_sync;
  logic       cart_present;
  logic       cart_fault;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pin_sync #(
    .W (2)
  ) u_cart_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .pin_i   ({cart_fault_i, cart_present_i}),
    .sync_o  (cart_sync)
  );

  assign cart_present = cart_sync[0];
  assign cart_fault   = cart_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  keep_mode_e        keep_mode;
  logic [IDX_W-1:0]  clear_first;
  logic [IDX_W-1:0]  clear_last;
  logic [1:0]        request;
  logic [1:0]        taken;
  logic [DATA_W-1:0] backup_result_status;
  logic [DATA_W-1:0] restore_start_index;
  logic [DATA_W-1:0] restore_word_count;
  logic [IDX_W-1:0]  dreg_index;
  logic [DATA_W-1:0] result_code;
  state_e            state;
  logic [IDX_W-1:0]  ptr;
  logic [DATA_W-1:0] remaining;
  logic [DATA_W-1:0] apb_dreg_rdata;
  logic [DATA_W-1:0] backup_rdata;

  logic              wr_en;
  logic              setup;
  logic              mapped;
  logic              busy;
  logic              store_ok;
  logic              acked;
  logic              nv_fail;
  logic              accessing;
  logic              apb_dreg_we;
  logic              fsm_dreg_we;
  logic [IDX_W-1:0]  span_last;
  logic [16:0]       span_words;
  logic [16:0]       restore_end;

  assign busy       = (state != S_IDLE);
  assign setup      = psel_i && !penable_i;
  assign wr_en      = psel_i && penable_i && pwrite_i && mapped;
  assign span_last  = SMALL_VARIANT ? LAST_SMALL : LAST_LARGE;
  assign span_words = SMALL_VARIANT ? SPAN_SMALL : SPAN_LARGE;
  assign restore_end = {1'b0, restore_start_index} + {1'b0, restore_word_count};
  // cartridge takes over whenever present; a variant without internal store fails
  assign store_ok   = cart_present ? !cart_fault : INTERNAL_STORE;
  assign acked      = nv_req_o && nv_ack_i;
  assign nv_fail    = acked && nv_err_i;

  always_comb begin
    case (paddr_i)
      OFS_MODE, OFS_REQUEST, OFS_CLEAR_FIRST, OFS_CLEAR_LAST, OFS_STATUS,
      OFS_RESTORE_START, OFS_RESTORE_COUNT, OFS_DREG_INDEX, OFS_DREG_DATA,
      OFS_INFO: mapped = 1'b1;
      default:  mapped = 1'b0;
    endcase
  end

  // no wait states; read data is captured during the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= '0;
    end else if (setup) begin
      case (paddr_i)
        OFS_MODE:          prdata_o <= {30'h00000000, keep_mode};
        OFS_REQUEST:       prdata_o <= {30'h00000000, request};
        OFS_CLEAR_FIRST:   prdata_o <= {21'h000000, clear_first};
        OFS_CLEAR_LAST:    prdata_o <= {21'h000000, clear_last};
        OFS_STATUS:        prdata_o <= {16'h0000, backup_result_status};
        OFS_RESTORE_START: prdata_o <= {16'h0000, restore_start_index};
        OFS_RESTORE_COUNT: prdata_o <= {16'h0000, restore_word_count};
        OFS_DREG_INDEX:    prdata_o <= {21'h000000, dreg_index};
        OFS_DREG_DATA:     prdata_o <= {16'h0000, apb_dreg_rdata};
        OFS_INFO:          prdata_o <= {29'h00000000, cart_fault, cart_present, busy};
        default:           prdata_o <= '0;
      endcase
    end
  end

  // keep/clear configuration survives a start of operation
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      keep_mode   <= MODE_RESET;
      clear_first <= CLEAR_FIRST_RESET;
      clear_last  <= CLEAR_LAST_RESET;
      dreg_index  <= '0;
    end else if (wr_en) begin
      if (paddr_i == OFS_MODE && pwdata_i[1:0] <= 2'(CLEAR_RANGE)) begin
        keep_mode <= keep_mode_e'(pwdata_i[1:0]);
      end
      if (paddr_i == OFS_CLEAR_FIRST && pwdata_i <= 32'(LAST_LARGE)) begin
        clear_first <= pwdata_i[IDX_W-1:0];
      end
      if (paddr_i == OFS_CLEAR_LAST && pwdata_i <= 32'(LAST_LARGE)) begin
        clear_last <= pwdata_i[IDX_W-1:0];
      end
      if (paddr_i == OFS_DREG_INDEX) begin
        dreg_index <= pwdata_i[IDX_W-1:0];
      end
    end
  end

  // restore parameters are frozen while a transfer runs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      restore_start_index <= '0;
      restore_word_count  <= '0;
    end else if (run_start_i) begin
      restore_start_index <= '0;
      restore_word_count  <= '0;
    end else if (wr_en && !busy) begin
      if (paddr_i == OFS_RESTORE_START) begin
        restore_start_index <= pwdata_i[DATA_W-1:0];
      end
      if (paddr_i == OFS_RESTORE_COUNT) begin
        restore_word_count <= pwdata_i[DATA_W-1:0];
      end
    end
  end

  // a software write in the finishing cycle wins over the hardware clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      request <= '0;
    end else if (run_start_i) begin
      request <= '0;
    end else if (wr_en && paddr_i == OFS_REQUEST) begin
      request <= pwdata_i[1:0];
    end else if (state == S_FINISH) begin
      request <= request & ~taken;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      backup_result_status <= ST_NONE;
    end else if (run_start_i) begin
      backup_result_status <= ST_NONE;
    end else if (state == S_IDLE && scan_end_i && |request) begin
      backup_result_status <= ST_BUSY;
    end else if (state == S_FINISH) begin
      backup_result_status <= result_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= S_IDLE;
      taken       <= '0;
      ptr         <= '0;
      remaining   <= '0;
      result_code <= ST_NONE;
    end else if (run_start_i) begin
      state <= S_IDLE;
      taken <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (scan_end_i && |request) begin
            taken <= request;
            state <= request[REQ_WRITE_BIT] ? S_WR_OPEN : S_RD_CHECK;
          end
        end
        S_WR_OPEN: begin
          if (!store_ok || nv_fail) begin
            result_code <= ST_NOACCESS;
            state       <= taken[REQ_READ_BIT] ? S_RD_CHECK : S_FINISH;
          end else if (acked) begin
            ptr   <= '0;
            state <= S_WR_WORD;
          end
        end
        S_WR_WORD: begin
          if (nv_fail) begin
            result_code <= ST_NOACCESS;
            state       <= taken[REQ_READ_BIT] ? S_RD_CHECK : S_FINISH;
          end else if (acked) begin
            if (ptr == span_last) begin
              state <= S_WR_SEAL;
            end else begin
              ptr <= ptr + 11'h001;
            end
          end
        end
        S_WR_SEAL: begin
          if (acked) begin
            result_code <= nv_err_i ? ST_NOACCESS : ST_OK;
            state       <= taken[REQ_READ_BIT] ? S_RD_CHECK : S_FINISH;
          end
        end
        S_RD_CHECK: begin
          ptr       <= restore_start_index[IDX_W-1:0];
          remaining <= restore_word_count;
          if (restore_word_count == '0 ||
              restore_start_index > {5'h00, span_last} ||
              restore_end > span_words) begin
            result_code <= ST_BADPARAM;
            state       <= S_FINISH;
          end else if (!store_ok) begin
            result_code <= ST_NOACCESS;
            state       <= S_FINISH;
          end else begin
            state <= S_RD_MARK;
          end
        end
        S_RD_MARK: begin
          if (nv_fail) begin
            result_code <= ST_NOACCESS;
            state       <= S_FINISH;
          end else if (acked && nv_rdata_i != MARKER_VALID) begin
            result_code <= ST_NODATA;
            state       <= S_FINISH;
          end else if (acked) begin
            state <= S_RD_WORD;
          end
        end
        S_RD_WORD: begin
          if (nv_fail) begin
            result_code <= ST_NOACCESS;
            state       <= S_FINISH;
          end else if (acked) begin
            if (remaining == 16'h0001) begin
              result_code <= ST_OK;
              state       <= S_FINISH;
            end else begin
              ptr       <= ptr + 11'h001;
              remaining <= remaining - 16'h0001;
            end
          end
        end
        S_FINISH: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile store port

  assign accessing = (state == S_WR_OPEN || state == S_WR_WORD || state == S_WR_SEAL ||
                      state == S_RD_MARK || state == S_RD_WORD);

  // marker is voided first and sealed last, so a torn image reads as invalid
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nv_req_o   <= 1'b0;
      nv_we_o    <= 1'b0;
      nv_cart_o  <= 1'b0;
      nv_addr_o  <= '0;
      nv_wdata_o <= '0;
    end else if (run_start_i || acked) begin
      nv_req_o <= 1'b0;
    end else if (accessing && !nv_req_o && store_ok) begin
      nv_req_o  <= 1'b1;
      nv_cart_o <= cart_present;
      case (state)
        S_WR_OPEN: begin
          nv_we_o    <= 1'b1;
          nv_addr_o  <= MARKER_ADDR;
          nv_wdata_o <= MARKER_VOID;
        end
        S_WR_WORD: begin
          nv_we_o    <= 1'b1;
          nv_addr_o  <= {1'b0, ptr};
          nv_wdata_o <= backup_rdata;
        end
        S_WR_SEAL: begin
          nv_we_o    <= 1'b1;
          nv_addr_o  <= MARKER_ADDR;
          nv_wdata_o <= MARKER_VALID;
        end
        S_RD_MARK: begin
          nv_we_o   <= 1'b0;
          nv_addr_o <= MARKER_ADDR;
        end
        default: begin
          nv_we_o   <= 1'b0;
          nv_addr_o <= {1'b0, ptr};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data register array

  // restore wins the write port; a software data write in the same cycle as a restored word is dropped
  assign fsm_dreg_we = (state == S_RD_WORD) && acked && !nv_err_i;
  assign apb_dreg_we = wr_en && (paddr_i == OFS_DREG_DATA) && !fsm_dreg_we;

  dreg_array u_array (
    .clk_i     (clk_i),
    .clear_i   (run_start_i),
    .mode_i    (keep_mode),
    .first_i   (clear_first),
    .last_i    (clear_last),
    .we_i      (fsm_dreg_we || apb_dreg_we),
    .widx_i    (fsm_dreg_we ? ptr : dreg_index),
    .wdata_i   (fsm_dreg_we ? nv_rdata_i : pwdata_i[DATA_W-1:0]),
    .ridx_a_i  (dreg_index),
    .rdata_a_o (apb_dreg_rdata),
    .ridx_b_i  (ptr),
    .rdata_b_o (backup_rdata)
  );

endmodule
`default_nettype wire

// file: verif/dreg_backup_monitor.sv
// assertions on the store handshake and bus error flag of dreg_backup
// bound to each dreg_backup instance; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module dreg_backup_monitor
  import dreg_backup_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic                 run_start_i,
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic [11:0]          paddr_i,
  input wire logic                 pslverr_o,
  input wire logic                 cart_present_i,
  input wire logic                 nv_req_o,
  input wire logic                 nv_we_o,
  input wire logic                 nv_cart_o,
  input wire logic [NV_ADDR_W-1:0] nv_addr_o,
  input wire logic [DATA_W-1:0]    nv_wdata_o,
  input wire logic                 nv_ack_i
);
  localparam logic [11:0] SPAN = SMALL_VARIANT ? 12'h190 : 12'h7D0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [11:0] wcnt;
  logic [11:0] last;
  ////////////////////////////////////////
  // data words acknowledged since the last marker write, void or seal, and last address served
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wcnt <= 12'h000;
      last <= MARKER_ADDR;
    end else if (nv_req_o && nv_ack_i) begin
      last <= nv_addr_o;
      if (nv_we_o && nv_addr_o == MARKER_ADDR) wcnt <= 12'h000;
      else if (nv_we_o) wcnt <= wcnt + 12'h001;
    end
  end
  ////////////////////////////////////////
  chk_err_unmapped: assert property (psel_i && penable_i && paddr_i > OFS_INFO |-> pslverr_o)
    else $error("no bus error on unmapped address");
  chk_err_mapped: assert property (psel_i && penable_i && paddr_i <= OFS_INFO
    && paddr_i[1:0] == 2'b00 |-> !pslverr_o) else $error("bus error on mapped address");
  chk_req_hold: assert property (nv_req_o && !nv_ack_i && !run_start_i |=> nv_req_o
    && $stable({nv_we_o, nv_cart_o, nv_addr_o, nv_wdata_o})) else $error("request dropped");
  chk_req_gap: assert property (nv_ack_i |=> !nv_req_o)
    else $error("no idle cycle after store answer");
  chk_start_abort: assert property (run_start_i |=> !nv_req_o)
    else $error("transfer not aborted at start");
  chk_cart_route: assert property (nv_req_o && $past(cart_present_i, 8) == cart_present_i
    |-> nv_cart_o == cart_present_i) else $error("store target wrong");
  chk_marker_last: assert property (nv_req_o && nv_we_o && nv_addr_o == MARKER_ADDR
    && nv_wdata_o == MARKER_VALID |-> wcnt == SPAN) else $error("marker before all words");
  chk_addr_step: assert property ($rose(nv_req_o) && last != MARKER_ADDR
    && nv_addr_o != MARKER_ADDR |-> nv_addr_o == last + 12'h001) else $error("address skipped");
endmodule
bind dreg_backup dreg_backup_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) mon (.clk_i, .resetn_i,
  .run_start_i, .psel_i, .penable_i, .paddr_i, .pslverr_o, .cart_present_i, .nv_req_o,
  .nv_we_o, .nv_cart_o, .nv_addr_o, .nv_wdata_o, .nv_ack_i);
`default_nettype wire

// file: verif/nv_store_model.sv
// behavioural nonvolatile store with an internal bank and a cartridge bank
// answers after 0 to 3 waits set by the address; fail_i flags an error
`timescale 1ns/10ps
`default_nettype none
module nv_store_model
  import dreg_backup_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 fail_i,
  input  wire logic                 req_i,
  input  wire logic                 we_i,
  input  wire logic                 cart_i,
  input  wire logic [NV_ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  output logic      [DATA_W-1:0]    rdata_o,
  output logic                      ack_o,
  output logic                      err_o
);
  // blank banks, so a restore before any backup finds no valid marker
  logic [DATA_W-1:0] mem [2][4096] = '{default: '0};
  logic [1:0]        dly = 2'b00;
  logic              a = 1'b0;
  logic              e = 1'b0;
  logic [DATA_W-1:0] r = 16'h0000;
  assign ack_o   = a;
  assign err_o   = e;
  assign rdata_o = r;
  always_ff @(posedge clk_i) begin
    a <= 1'b0;
    e <= 1'b0;
    r <= ~r; // read data is not held between answers
    if (req_i && !a) begin
      dly <= dly + 2'b01;
      if (dly == addr_i[1:0]) begin
        dly <= 2'b00;
        a   <= 1'b1;
        e   <= fail_i;
        if (we_i) mem[cart_i][addr_i] <= wdata_i;
        else r <= mem[cart_i][addr_i];
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/dreg_backup_tb.sv
// self-checking bench for dreg_backup, small variant with internal store
// drives APB, scan and start pulses and cartridge pins; nv_store_model is the store
`timescale 1ns/10ps
`default_nettype none
module dreg_backup_tb
  import dreg_backup_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, scan = 1'b0, start = 1'b0, cart = 1'b0, fault = 1'b0;
  logic        fail = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        pready, pslverr, req, we, ncart, ack, nerr;
  logic [11:0] paddr = 12'h000, naddr;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] nwd, nrd, exp [2000], saved [2000];
  int          errors = 0, n_compared = 0, seed = 23488;
  int          bad [3][2] = '{'{0, 0}, '{400, 1}, '{399, 2}};
  always #25 clk = ~clk;
  dreg_backup #(.SMALL_VARIANT(1'b1), .INTERNAL_STORE(1'b1)) dut (
    .clk_i(clk), .resetn_i(rstn), .scan_end_i(scan), .run_start_i(start), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cart_present_i(cart), .cart_fault_i(fault),
    .nv_req_o(req), .nv_we_o(we), .nv_cart_o(ncart), .nv_addr_o(naddr), .nv_wdata_o(nwd),
    .nv_rdata_i(nrd), .nv_ack_i(ack), .nv_err_i(nerr));
  nv_store_model nv (.clk_i(clk), .fail_i(fail), .req_i(req), .we_i(we), .cart_i(ncart),
    .addr_i(naddr), .wdata_i(nwd), .rdata_o(nrd), .ack_o(ack), .err_o(nerr));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle pulse on the start input when to_start is set, on the scan end input otherwise
  task automatic pulse(input bit to_start);
    if (to_start) start <= 1'b1;
    else scan <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    scan <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put(input int i, input logic [15:0] v);
    apb(1'b1, OFS_DREG_INDEX, 32'(i));
    apb(1'b1, OFS_DREG_DATA, {16'h0, v});
    exp[i] = v;
  endtask
  task automatic chkr(input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      apb(1'b1, OFS_DREG_INDEX, 32'(i));
      apb(1'b0, OFS_DREG_DATA, 32'h0);
      chk(q, {16'h0, exp[i]});
    end
  endtask
  task automatic xfer(input logic [1:0] r, input logic [15:0] st);
    apb(1'b1, OFS_REQUEST, {30'h0, r});
    pulse(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    if (r[0] && st === ST_OK) chk(q, {16'h0, ST_BUSY});
    while (q[15:0] === ST_BUSY) apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, {16'h0, st});
    apb(1'b0, OFS_REQUEST, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic restore(input int s, input int c, input logic [15:0] st);
    apb(1'b1, OFS_RESTORE_START, 32'(s));
    apb(1'b1, OFS_RESTORE_COUNT, 32'(c));
    xfer(2'b10, st);
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #(50 * 100000);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, {16'h0, ST_NONE});
    apb(1'b0, 12'h100, 32'h0);
    for (int i = 0; i < 2000; i++) put(i, 16'($random(seed)));
    pulse(1'b1);
    chkr(0, 400);
    xfer(2'b01, ST_OK);
    saved = exp;
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_RESTORE_START, 32'h5);
    pulse(1'b1);
    apb(1'b0, OFS_RESTORE_START, 32'h0);
    chk(q, 32'h0);
    exp = '{default: 16'h0};
    chkr(0, 400);
    restore(0, 400, ST_OK);
    for (int i = 0; i < 400; i++) exp[i] = saved[i];
    chkr(0, 400);
    put(1999, 16'h5A5A);
    apb(1'b1, OFS_MODE, 32'h2);
    apb(1'b1, OFS_CLEAR_FIRST, 32'h64);
    apb(1'b1, OFS_CLEAR_FIRST, 32'h7D0);
    apb(1'b0, OFS_CLEAR_FIRST, 32'h0);
    chk(q, 32'h64);
    apb(1'b1, OFS_CLEAR_LAST, 32'h7CF);
    chkr(99, 101);
    pulse(1'b1);
    for (int i = 100; i < 2000; i++) exp[i] = 16'h0;
    chkr(0, 400);
    chkr(1999, 2000);
    for (int k = 0; k < 3; k++) restore(bad[k][0], bad[k][1], ST_BADPARAM);
    chkr(99, 101);
    restore(150, 250, ST_OK);
    for (int i = 150; i < 400; i++) exp[i] = saved[i];
    chkr(0, 400);
    cart <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_INFO, 32'h0);
    chk(q, 32'h2);
    restore(0, 1, ST_NODATA);
    put(0, 16'($random(seed)));
    xfer(2'b01, ST_OK);
    cart <= 1'b0;
    put(0, 16'h0000);
    repeat (10) @(posedge clk);
    restore(0, 1, ST_OK);
    exp[0] = saved[0];
    chkr(0, 1);
    // the fault pin only counts with a cartridge seated; without one the internal store serves
    cart <= 1'b1;
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_INFO, 32'h0);
    chk(q, 32'h6);
    xfer(2'b01, ST_NOACCESS);
    cart <= 1'b0;
    fault <= 1'b0;
    fail <= 1'b1;
    repeat (10) @(posedge clk);
    restore(0, 1, ST_NOACCESS);
    fail <= 1'b0;
    apb(1'b1, OFS_RESTORE_START, 32'h0);
    apb(1'b1, OFS_RESTORE_COUNT, 32'h190);
    xfer(2'b11, ST_OK);
    chkr(100, 150);
    apb(1'b1, OFS_REQUEST, 32'h1);
    pulse(1'b0);
    repeat (40) @(posedge clk);
    pulse(1'b1);
    restore(0, 1, ST_NODATA);
    print_verdict();
  end
endmodule
`default_nettype wire
